// >>> core/wmg_marker_gen.sv
// Contract
// - four independent marker channels flag sample positions in a segment
// - enabled set marker at playback drives the matching event output
// - marker 1 drives the first event connector and an auxiliary pin
// - marker 2 drives both trigger connectors and an auxiliary pin
// - markers 3 and 4 drive auxiliary pins only
// - per-marker polarity; positions single sample or contiguous range
// - any marker may drive level-loop hold, or RF blanking with hold
// - marker outputs registered one clock after their I and Q samples
// - waveform loaded without markers gets all markers cleared
// - built-in test segments mark only the first sample on all four markers
// - point marker edits accepted only while segment is resident in playback memory
// - polarity and routing persist until reconfigured, preset or power cycle
// - during hold the loop holds the average of samples taken while marker high
// - loop samples output whenever routed marker signal is high
// - negative polarity: low at set positions, high at unset; positive reverse
// - hold is in effect while its routed marker is low
// - blanking active while routed marker low, stops when it goes high
// - active blanking also asserts level-loop hold
`timescale 1ns/1ps
`default_nettype none
module wmg_marker_gen
  import wmg_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     sample_valid,
  input  wire logic [wmg_pkg::ADDR_W-1:0]  sample_index,
  input  wire logic [wmg_pkg::LEVEL_W-1:0] sample_i,
  input  wire logic [wmg_pkg::LEVEL_W-1:0] sample_q,
  input  wire logic [wmg_pkg::LEVEL_W-1:0] sample_level,
  input  wire logic                     load_no_markers,
  output logic      [wmg_pkg::LEVEL_W-1:0] out_i,
  output logic      [wmg_pkg::LEVEL_W-1:0] out_q,
  output logic                          out_valid,
  output logic                          event1_bnc,
  output logic                          first_trigger_connector,
  output logic                          second_trigger_connector,
  output logic      [3:0]               aux_event,
  output logic                          level_hold,
  output logic                          rf_blank,
  output logic      [wmg_pkg::LEVEL_W-1:0] hold_level
);
  import wmg_pkg::*;

  logic [NUM_MARKERS-1:0] mem [DEPTH];
  logic [3:0]             ena;
  logic [3:0]             pol;
  logic                   resident;
  logic [2:0]             route_hold;
  logic [2:0]             route_blank;
  logic [ADDR_W-1:0]      seg_len;
  wmg_init_t              init_state;
  logic [ADDR_W-1:0]      init_addr;
  logic                   init_test;
  logic [NUM_MARKERS-1:0] mk_raw;
  logic [NUM_MARKERS-1:0] mk_sig;
  logic [ACC_W-1:0]       acc;
  logic [CNT_W:0]         acc_cnt;
  logic [1:0]             edit_err;
  logic [LEVEL_W-1:0]     out_level;

  wire bus_wr  = psel && penable && pwrite;
  wire hit_ctrl  = (paddr == OFF_CTRL);
  wire hit_route = (paddr == OFF_ROUTE);
  wire hit_edit  = (paddr == OFF_EDIT);
  wire hit_stat  = (paddr == OFF_STATUS);
  wire hit_len   = (paddr == OFF_LENGTH);
  wire hit_lvl   = (paddr == OFF_HOLDLVL);
  wire mapped    = hit_ctrl | hit_route | hit_edit | hit_stat | hit_len | hit_lvl;
  wire init_busy = (init_state == WMG_CLEAR);
  wire cfg_reset = bus_wr && hit_ctrl && pwdata[CTRL_RESET];
  wire edit_go   = bus_wr && hit_edit && !init_busy;
  wire edit_init = edit_go && (pwdata[EDIT_CLEAR_ALL] || pwdata[EDIT_TEST_SEG]);
  // clear-all and test-segment loads bypass the resident check; point edits are refused while not resident
  wire edit_pt   = edit_go && !edit_init && resident;
  wire edit_rej  = edit_go && !edit_init && !resident;
  wire start_clr = load_no_markers || edit_init;
  wire [ADDR_W-1:0] e_addr = pwdata[EDIT_ADDR_LSB +: ADDR_W];
  wire [3:0]        e_mask = pwdata[EDIT_MASK_LSB +: 4];
  wire [3:0]        e_val  = pwdata[EDIT_VAL_LSB +: 4];
  wire [3:0]        e_old  = mem[e_addr];
  wire [3:0]        e_new  = (e_old & ~e_mask) | (e_val & e_mask);
  wire [3:0]        init_word = (init_test && init_addr == '0) ? 4'hf : 4'h0;

  // routed marker signals, selector 0 is none
  wire hold_src  = (route_hold  != ROUTE_NONE) && mk_sig[route_hold[1:0] - 2'h1];
  wire blank_src = (route_blank != ROUTE_NONE) && mk_sig[route_blank[1:0] - 2'h1];
  wire blank_on  = (route_blank != ROUTE_NONE) && !blank_src;
  wire hold_on   = ((route_hold != ROUTE_NONE) && !hold_src) || blank_on;
  wire sample_hi = (route_hold != ROUTE_NONE) ? hold_src : blank_src;
  wire [ACC_W-1:0] avg = (acc_cnt == '0) ? '0 : acc / ACC_W'(acc_cnt);

  // marker lookup registered with the sample data; the event outputs leave one clock after it
  genvar g;
  generate
    for (g = 0; g < NUM_MARKERS; g++)
    begin : g_mk
      assign mk_sig[g] = ena[g] & (mk_raw[g] ^ pol[g]);
    end
  endgenerate

  // marker memory is not reset; load or clear it before playback
  always_ff @(posedge pclk)
  begin
    if (init_busy)
      mem[init_addr] <= init_word;
    else if (edit_pt)
      mem[e_addr] <= e_new;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mk_raw    <= '0;
      out_i     <= '0;
      out_q     <= '0;
      out_valid <= 1'b0;
      out_level <= '0;
    end
    else
    begin
      mk_raw    <= sample_valid ? mem[sample_index] : 4'h0;
      out_i     <= sample_i;
      out_q     <= sample_q;
      out_valid <= sample_valid;
      out_level <= sample_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      event1_bnc               <= 1'b0;
      first_trigger_connector  <= 1'b0;
      second_trigger_connector <= 1'b0;
      aux_event                <= 4'h0;
      level_hold               <= 1'b0;
      rf_blank                 <= 1'b0;
    end
    else
    begin
      event1_bnc               <= mk_sig[0];
      first_trigger_connector  <= mk_sig[1];
      second_trigger_connector <= mk_sig[1];
      aux_event                <= mk_sig;
      level_hold               <= hold_on;
      rf_blank                 <= blank_on;
    end
  end

  // level loop averager: accumulate while routed marker high, freeze on hold
  // out_level is used so each level meets the marker of its own sample
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc        <= '0;
      acc_cnt    <= '0;
      hold_level <= '0;
    end
    else if (hold_on)
      hold_level <= avg[LEVEL_W-1:0];
    else if (sample_hi && out_valid)
    begin
      if (acc_cnt[CNT_W])
      begin
        acc     <= ACC_W'(out_level);
        acc_cnt <= (CNT_W+1)'(1);
      end
      else
      begin
        acc     <= acc + ACC_W'(out_level);
        acc_cnt <= acc_cnt + 1'b1;
      end
    end
    else if (!sample_hi && acc_cnt != '0 && !hold_on)
      hold_level <= avg[LEVEL_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ena         <= CTRL_RESET_VAL[CTRL_ENA_LSB +: 4];
      pol         <= CTRL_RESET_VAL[CTRL_POL_LSB +: 4];
      resident    <= CTRL_RESET_VAL[CTRL_RESIDENT];
      route_hold  <= ROUTE_RESET_VAL[ROUTE_HOLD_LSB +: 3];
      route_blank <= ROUTE_RESET_VAL[ROUTE_BLANK_LSB +: 3];
      seg_len     <= LENGTH_RESET_VAL;
    end
    else if (cfg_reset)
    begin
      ena         <= CTRL_RESET_VAL[CTRL_ENA_LSB +: 4];
      pol         <= CTRL_RESET_VAL[CTRL_POL_LSB +: 4];
      route_hold  <= ROUTE_NONE;
      route_blank <= ROUTE_NONE;
    end
    else if (bus_wr && hit_ctrl)
    begin
      ena      <= pwdata[CTRL_ENA_LSB +: 4];
      pol      <= pwdata[CTRL_POL_LSB +: 4];
      resident <= pwdata[CTRL_RESIDENT];
    end
    // a selector above four is stored as none
    else if (bus_wr && hit_route)
    begin
      route_hold  <= (pwdata[ROUTE_HOLD_LSB +: 3] > 3'h4) ? ROUTE_NONE
                                                          : pwdata[ROUTE_HOLD_LSB +: 3];
      route_blank <= (pwdata[ROUTE_BLANK_LSB +: 3] > 3'h4) ? ROUTE_NONE
                                                           : pwdata[ROUTE_BLANK_LSB +: 3];
    end
    else if (bus_wr && hit_len)
      seg_len <= pwdata[ADDR_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_state <= WMG_IDLE;
      init_addr  <= '0;
      init_test  <= 1'b0;
    end
    else
    begin
      case (init_state)
        WMG_IDLE, WMG_DONE:
        begin
          if (start_clr)
          begin
            init_state <= WMG_CLEAR;
            init_addr  <= '0;
            init_test  <= edit_init && pwdata[EDIT_TEST_SEG];
          end
        end
        // walks the marker words from 0 to the last index, one word a cycle
        WMG_CLEAR:
        begin
          if (init_addr == seg_len)
            init_state <= WMG_DONE;
          else
            init_addr <= init_addr + 1'b1;
        end
        default:
          init_state <= WMG_IDLE;
      endcase
    end
  end

  // sticky edit error: bit0 rejected not resident, bit1 rejected busy; set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      edit_err <= 2'b00;
    else
      edit_err <= (bus_wr && hit_stat ? edit_err & ~pwdata[1:0] : edit_err)
                  | {bus_wr && hit_edit && init_busy, edit_rej};
  end

  wire [31:0] rd_mux =
    hit_ctrl  ? {23'h0, resident, pol, ena} :
    hit_route ? {25'h0, route_blank, 1'b0, route_hold} :
    hit_stat  ? {24'h0, init_busy, rf_blank, level_hold, 3'h0, edit_err} :
    hit_len   ? {22'h0, seg_len} :
    hit_lvl   ? {16'h0, hold_level} :
    32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // answer in the cycle after setup: zero wait states
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
    end
  end
endmodule
`default_nettype wire

// >>> shared/wmg_pkg.sv
package wmg_pkg;
  localparam int NUM_MARKERS = 4;
  localparam int ADDR_W      = 10;
  localparam int DEPTH       = 1024;
  localparam int LEVEL_W     = 16;
  localparam int ACC_W       = 26;
  localparam int CNT_W       = 10;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_ROUTE    = 12'h004;
  localparam logic [11:0] OFF_EDIT     = 12'h008;
  localparam logic [11:0] OFF_STATUS   = 12'h00c;
  localparam logic [11:0] OFF_LENGTH   = 12'h010;
  localparam logic [11:0] OFF_HOLDLVL  = 12'h014;
  // ctrl fields
  localparam int CTRL_ENA_LSB  = 0;
  localparam int CTRL_POL_LSB  = 4;
  localparam int CTRL_RESIDENT = 8;
  localparam int CTRL_RESET    = 9;
  // route fields: 3-bit selector, 0 none, 1..4 marker
  localparam int ROUTE_HOLD_LSB  = 0;
  localparam int ROUTE_BLANK_LSB = 4;
  localparam logic [2:0] ROUTE_NONE = 3'h0;
  // edit fields
  localparam int EDIT_ADDR_LSB  = 0;
  localparam int EDIT_MASK_LSB  = 16;
  localparam int EDIT_VAL_LSB   = 20;
  localparam int EDIT_CLEAR_ALL = 24;
  localparam int EDIT_TEST_SEG  = 25;
  localparam logic [31:0] CTRL_RESET_VAL  = 32'h0000_0000;
  localparam logic [7:0]  ROUTE_RESET_VAL = 8'h00;
  localparam logic [ADDR_W-1:0] LENGTH_RESET_VAL = 10'h3ff;
  typedef enum logic [2:0]
  {
    WMG_IDLE  = 3'b001,
    WMG_CLEAR = 3'b010,
    WMG_DONE  = 3'b100
  } wmg_init_t;
endpackage

// >>> tb/wmg_marker_gen_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wmg_marker_gen_monitor
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_i,
  input  wire logic [15:0] out_i,
  input  wire logic        out_valid,
  input  wire logic        event1_bnc,
  input  wire logic        first_trigger_connector,
  input  wire logic        second_trigger_connector,
  input  wire logic [3:0]  aux_event,
  input  wire logic        level_hold,
  input  wire logic        rf_blank
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ev1_aux: assert property (event1_bnc == aux_event[0])
    else $error("event1 differs from aux pin");
  a_trig_pair: assert property (first_trigger_connector == second_trigger_connector)
    else $error("trigger connectors differ");
  a_ev2_aux: assert property (first_trigger_connector == aux_event[1])
    else $error("trigger differs from aux pin");
  a_blank_hold: assert property (rf_blank |-> level_hold)
    else $error("blanking without hold");
  a_valid_align: assert property (out_valid == $past(sample_valid))
    else $error("out_valid misaligned");
  a_data_align: assert property (out_valid |-> out_i == $past(sample_i))
    else $error("out_i misaligned");
  a_reset_quiet: assert property ($rose(presetn) |-> !level_hold && !rf_blank)
    else $error("hold or blank active after reset");
  a_zero_wait: assert property (psel && !penable |=> pready && penable)
    else $error("access phase not answered");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  c_blank: cover property (rf_blank);
  c_hold: cover property (level_hold && !rf_blank);
  c_err: cover property (pslverr);
endmodule
bind wmg_marker_gen wmg_marker_gen_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .sample_valid(sample_valid), .sample_i(sample_i), .out_i(out_i),
  .out_valid(out_valid), .event1_bnc(event1_bnc),
  .first_trigger_connector(first_trigger_connector),
  .second_trigger_connector(second_trigger_connector),
  .aux_event(aux_event), .level_hold(level_hold), .rf_blank(rf_blank));
`default_nettype wire

// >>> tb/wmg_event_rx.sv
`timescale 1ns/1ps
`default_nettype none
// external instrument: counts trigger pulses arriving on the first trigger connector
module wmg_event_rx
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       first_trigger_connector,
  output var  logic [7:0] edge_cnt
);
  logic last;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last <= 1'b0;
      edge_cnt <= 8'h00;
    end
    else
    begin
      last <= first_trigger_connector;
      if (first_trigger_connector && !last)
      begin
        edge_cnt <= edge_cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/wmg_marker_gen_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wmg_marker_gen_tb;
  import wmg_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic pready, pslverr, rerr, sample_valid = 0, load_no_markers = 0;
  logic [9:0] sample_index = 0;
  logic [15:0] sample_i = 0, sample_q = 0, sample_level = 0, out_i, out_q, hold_level;
  logic out_valid, event1_bnc, first_trigger_connector, second_trigger_connector;
  logic level_hold, rf_blank;
  logic [3:0] aux_event;
  logic [7:0] edge_cnt, ecnt;
  int n_errors = 0, check_count = 0, cyc = 0;
  always #12.5 pclk = ~pclk;
  wmg_marker_gen uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample_index(sample_index),
    .sample_i(sample_i), .sample_q(sample_q), .sample_level(sample_level),
    .load_no_markers(load_no_markers), .out_i(out_i), .out_q(out_q),
    .out_valid(out_valid), .event1_bnc(event1_bnc),
    .first_trigger_connector(first_trigger_connector),
    .second_trigger_connector(second_trigger_connector), .aux_event(aux_event),
    .level_hold(level_hold), .rf_blank(rf_blank), .hold_level(hold_level));
  wmg_event_rx rx (.pclk(pclk), .presetn(presetn),
    .first_trigger_connector(first_trigger_connector), .edge_cnt(edge_cnt));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic play(input logic [9:0] ix, input logic [15:0] lv);
    sample_index <= ix; sample_level <= lv; sample_i <= lv; sample_q <= ~lv;
    sample_valid <= 1;
    repeat (4) @(posedge pclk);
  endtask
  task automatic idle();
    do apb(0, OFF_STATUS, 0); while (rdat[7] !== 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, OFF_CTRL, 0); chk(rdat, CTRL_RESET_VAL);
    apb(0, OFF_ROUTE, 0); chk(rdat[7:0], ROUTE_RESET_VAL);
    apb(0, OFF_LENGTH, 0); chk(rdat[9:0], LENGTH_RESET_VAL);
    apb(0, 12'h0f0, 0); chk(rerr, 1'b1);
    $display("reset test done");
    apb(1, OFF_CTRL, 32'h10f); apb(1, OFF_EDIT, 32'h0200_0000); idle();
    play(0, 0); chk(aux_event, 4'hf);
    play(1, 0); chk(aux_event, 4'h0);
    apb(1, OFF_CTRL, 32'h1ff);
    play(0, 0); chk(aux_event, 4'h0);
    play(1, 0); chk(aux_event, 4'hf);
    apb(1, OFF_CTRL, 32'h100);
    play(1, 0); chk(aux_event, 4'h0);
    $display("polarity test done");
    apb(1, OFF_CTRL, 32'h10f); apb(0, OFF_CTRL, 0); chk(rdat, 32'h10f);
    apb(1, OFF_ROUTE, 32'h1);
    play(0, 16'h0200); chk({level_hold, rf_blank}, 2'b00);
    chk(out_i, 16'h0200); chk(out_q, 16'hfdff);
    play(1, 16'h7777); chk({level_hold, rf_blank}, 2'b10);
    apb(0, OFF_HOLDLVL, 0); chk(rdat[15:0], 16'h0200);
    chk(hold_level, 16'h0200);
    apb(1, OFF_ROUTE, 32'h20);
    play(1, 0); chk({level_hold, rf_blank}, 2'b11);
    play(0, 0); chk({level_hold, rf_blank}, 2'b00);
    $display("routing test done");
    apb(1, OFF_CTRL, 32'h00f); apb(1, OFF_EDIT, 32'h00aa_0005);
    apb(0, OFF_STATUS, 0); chk(rdat[0], 1'b1);
    play(5, 0); chk(aux_event, 4'h0);
    ecnt = edge_cnt;
    apb(1, OFF_CTRL, 32'h10f); apb(1, OFF_EDIT, 32'h00aa_0005);
    play(5, 0); chk(aux_event, 4'ha);
    chk({event1_bnc, first_trigger_connector}, 2'b01);
    chk(edge_cnt, ecnt + 8'h01);
    apb(1, OFF_LENGTH, 32'h7); apb(1, OFF_EDIT, 32'h0100_0000);
    apb(1, OFF_EDIT, 32'h00aa_0005); apb(0, OFF_STATUS, 0); chk(rdat[1:0], 2'b11);
    apb(1, OFF_STATUS, 32'h3); idle(); chk(rdat[1:0], 2'b00);
    play(5, 0); chk(aux_event, 4'h0);
    $display("edit test done");
    apb(1, OFF_EDIT, 32'h00ff_0000); apb(1, OFF_ROUTE, 32'h3);
    load_no_markers <= 1;
    @(posedge pclk);
    load_no_markers <= 0;
    idle();
    play(0, 0); chk(aux_event, 4'h0);
    apb(0, OFF_ROUTE, 0); chk(rdat[7:0], 8'h03);
    apb(1, OFF_ROUTE, 32'h37); apb(0, OFF_ROUTE, 0); chk(rdat[7:0], 8'h30);
    apb(1, OFF_CTRL, 32'h200); apb(0, OFF_ROUTE, 0); chk(rdat[7:0], 8'h00);
    apb(0, OFF_CTRL, 0); chk(rdat, 32'h100);
    $display("clear test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
